// ### rtl/fsps_top.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module fsps_top #(
  parameter int OVP_CYCLES = fsps_pkg::OVP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Analog comparator flags
  input wire fsps_pkg::fsps_flags_t comp_flags,
  // Power stage controls
  output logic gate_drive_output,
  output logic startup_source_on,
  output logic soft_start_quarter,
  output logic burst_active,
  output logic latched_fault,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  fsps_pkg::fsps_regs_t s;
  fsps_pkg::fsps_regs_t n;
  fsps_pkg::fsps_flags_t f;
  logic tick;
  logic run_ok;
  logic fault_auto;
  logic olp_hit;
  logic bo_hit;
  logic scp_hit;

  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      fsps_pkg::ADDR_CTRL: reg_sel = 2'h1;
      fsps_pkg::ADDR_STATUS: reg_sel = 2'h2;
      fsps_pkg::ADDR_COUNT: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction

  assign f = s.sync2;
  // One timer cycle completes at each new charge ramp
  assign tick = f.tmr_phase & ~s.phase_d;
  assign run_ok = (s.state == fsps_pkg::ST_RUN) && !s.burst && s.ctrl[fsps_pkg::CTRL_SW_EN];
  assign olp_hit = f.fb_overload && tick && (s.olp_cnt == fsps_pkg::FAULT_COUNT - 6'h1);
  assign bo_hit = f.line_loss && tick && (s.bo_cnt == fsps_pkg::FAULT_COUNT - 6'h1);
  // Short-circuit check opens once the short blanking interval has passed
  assign scp_hit = s.gate && f.cs_short && (s.blank <= fsps_pkg::BLANK_SHORT_LEFT);
  assign fault_auto = olp_hit || bo_hit || scp_hit || s.otp;

  always_comb begin
    n = s;
    n.sync1 = comp_flags;
    n.sync2 = s.sync1;
    n.phase_d = f.tmr_phase;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // Over-temperature hysteresis
    if (f.temp_hot) begin
      n.otp = 1'b1;
    end else if (f.temp_cool) begin
      n.otp = 1'b0;
    end

    // Qualify supply overvoltage and timer pull-down with clock counters
    n.ovp_cnt = f.vcc_ovp ? s.ovp_cnt + 16'h1 : 16'h0;
    n.tlow_cnt = (f.tmr_low && s.state != fsps_pkg::ST_CHARGE) ? s.tlow_cnt + 16'h1 : 16'h0;

    // Fault counters run only while switching
    if (s.state == fsps_pkg::ST_RUN && f.fb_overload) begin
      if (tick) n.olp_cnt = s.olp_cnt + 6'h1;
    end else begin
      n.olp_cnt = 6'h0;
    end
    if (s.state == fsps_pkg::ST_RUN && f.line_loss) begin
      if (tick) n.bo_cnt = s.bo_cnt + 6'h1;
    end else begin
      n.bo_cnt = 6'h0;
    end

    case (s.state)
      fsps_pkg::ST_CHARGE: begin
        if (f.vcc_stop) n.state = fsps_pkg::ST_DETECT;
      end
      fsps_pkg::ST_DETECT: begin
        if (f.line_present) begin
          n.state = s.otp ? fsps_pkg::ST_WAIT_RESTART : fsps_pkg::ST_RUN;
          n.ss = 1'b1;
        end else if (!f.vcc_deadline) begin
          n.state = fsps_pkg::ST_WAIT_RESTART;
        end
      end
      fsps_pkg::ST_WAIT_RESTART, fsps_pkg::ST_XWAIT: begin
        if (!f.vcc_restart_ok) begin
          n.state = fsps_pkg::ST_CHARGE;
        end else if (f.line_present || !s.ctrl[fsps_pkg::CTRL_XC_EN]) begin
          n.xcnt = 6'h0;
          n.state = fsps_pkg::ST_WAIT_RESTART;
        end else if (tick) begin
          n.state = fsps_pkg::ST_XWAIT;
          n.xcnt = s.xcnt + 6'h1;
          if (s.xcnt == fsps_pkg::XC_DELAY - 6'h1) begin
            n.state = fsps_pkg::ST_XDIS;
            n.xcnt = 6'h0;
            n.xfirst = 1'b1;
          end
        end
      end
      fsps_pkg::ST_RUN: begin
        if (!f.vcc_uvlo_ok) begin
          n.state = fsps_pkg::ST_CHARGE;
        end else if (fault_auto) begin
          n.state = fsps_pkg::ST_WAIT_RESTART;
        end
        if (f.fb_burst_low) begin
          n.burst = 1'b1;
        end else if (f.fb_burst_high) begin
          n.burst = 1'b0;
        end
        if (f.tmr_ss_done) n.ss = 1'b0;
      end
      fsps_pkg::ST_XDIS: begin
        if (f.line_at_supply) begin
          n.state = fsps_pkg::ST_WAIT_RESTART;
          n.xcnt = 6'h0;
        end else if (tick) begin
          n.xcnt = s.xcnt + 6'h1;
          if (s.xcnt == (s.xfirst ? fsps_pkg::XC_FIRST : fsps_pkg::XC_REPEAT) - 6'h1) begin
            n.state = fsps_pkg::ST_XDET;
            n.xcnt = 6'h0;
          end
        end
      end
      fsps_pkg::ST_XDET: begin
        if (f.line_present) begin
          n.state = fsps_pkg::ST_RECON;
          n.xcnt = 6'h0;
        end else if (tick) begin
          n.xcnt = s.xcnt + 6'h1;
          if (s.xcnt == fsps_pkg::XC_DETECT - 6'h1) begin
            n.state = fsps_pkg::ST_XDIS;
            n.xcnt = 6'h0;
            n.xfirst = 1'b0;
          end
        end
      end
      fsps_pkg::ST_RECON: begin
        if (!f.vcc_reconnect_ok) n.state = fsps_pkg::ST_CHARGE;
      end
      fsps_pkg::ST_LATCH: begin
        if (!f.vcc_latch_hold) n.state = fsps_pkg::ST_CHARGE;
      end
      default: n.state = fsps_pkg::ST_CHARGE;
    endcase

    // Latched faults override every other state
    if (s.state != fsps_pkg::ST_LATCH) begin
      if (s.ovp_cnt == 16'(OVP_CYCLES - 1) && f.vcc_ovp) n.state = fsps_pkg::ST_LATCH;
      if (s.tlow_cnt == 16'(fsps_pkg::TLATCH_CYC - 1) && f.tmr_low) begin
        n.state = fsps_pkg::ST_LATCH;
      end
    end

    // Drive pulse with two blanking intervals
    if (!run_ok || n.state != fsps_pkg::ST_RUN) begin
      n.gate = 1'b0;
      n.blank = 8'h0;
    end else if (!s.gate) begin
      if (f.osc_set) begin
        n.gate = 1'b1;
        n.blank = fsps_pkg::BLANK_LOAD;
      end
    end else if (s.blank != 8'h0) begin
      n.blank = s.blank - 8'h1;
    end else if (f.cs_peak) begin
      n.gate = 1'b0;
    end

    if (n.state != fsps_pkg::ST_RUN) begin
      n.burst = 1'b0;
      if (n.state != fsps_pkg::ST_DETECT) n.ss = 1'b0;
    end
    n.src = (n.state == fsps_pkg::ST_CHARGE) || (n.state == fsps_pkg::ST_XDIS);
    n.latched = (n.state == fsps_pkg::ST_LATCH);

    // Register access: answer registered in the setup cycle, no wait states
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      case (reg_sel(paddr))
        2'h1: n.prdata = {30'h0, s.ctrl};
        2'h2: n.prdata = {23'h0, s.state, s.otp, s.latched, s.burst, s.ss, s.src};
        2'h3: n.prdata = {14'h0, s.xcnt, s.bo_cnt, s.olp_cnt};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s.pready && pwrite && reg_sel(paddr) == 2'h1) begin
      n.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= fsps_pkg::CTRL_RESET;
      s.src <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign gate_drive_output = s.gate;
  assign startup_source_on = s.src;
  assign soft_start_quarter = s.ss;
  assign burst_active = s.burst;
  assign latched_fault = s.latched;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  src_off_stop_a: assert property (s.state == fsps_pkg::ST_CHARGE && f.vcc_stop |=> !startup_source_on)
    else $error("source still on after stop-charge level");
  run_entry_a: assert property ($rose(s.state == fsps_pkg::ST_RUN) |->
    $past(s.state) == fsps_pkg::ST_DETECT && $past(f.line_present))
    else $error("switching started without line present");
  brownout_low_a: assert property (s.state == fsps_pkg::ST_DETECT && !f.line_present &&
    !f.vcc_deadline |=> !gate_drive_output [*2])
    else $error("gate driven after brown-out at start");
  restart_src_a: assert property (s.state == fsps_pkg::ST_WAIT_RESTART && !f.vcc_restart_ok &&
    !f.vcc_ovp && !f.tmr_low |=> startup_source_on && s.state == fsps_pkg::ST_CHARGE)
    else $error("source not on at fault restart level");
  uvlo_stop_a: assert property (s.state == fsps_pkg::ST_RUN && !f.vcc_uvlo_ok |=>
    !gate_drive_output && (startup_source_on || latched_fault))
    else $error("switching continued under undervoltage");
  burst_hold_a: assert property (s.burst && s.state == fsps_pkg::ST_RUN |=> !gate_drive_output)
    else $error("pulse issued during burst pause");
  olp_trip_a: assert property (s.state == fsps_pkg::ST_RUN && olp_hit |=>
    s.state != fsps_pkg::ST_RUN && !gate_drive_output)
    else $error("overload count 17 did not stop switching");
  blank_hold_a: assert property ($fell(gate_drive_output) |-> $past(s.blank) == 8'h0 ||
    s.state != fsps_pkg::ST_RUN || s.burst || !s.ctrl[fsps_pkg::CTRL_SW_EN])
    else $error("pulse ended inside blanking");
  latch_hold_a: assert property (s.state == fsps_pkg::ST_LATCH && f.vcc_latch_hold |=>
    latched_fault && !startup_source_on && !gate_drive_output)
    else $error("latched fault released early");
  detect_off_a: assert property (s.state == fsps_pkg::ST_XDET |-> !startup_source_on)
    else $error("source on during line detect phase");
  bo_trip_a: assert property (s.state == fsps_pkg::ST_RUN && bo_hit |=>
    s.state != fsps_pkg::ST_RUN && !gate_drive_output)
    else $error("brown-out count 17 did not stop switching");
  olp_clear_a: assert property (!f.fb_overload |=> s.olp_cnt == 6'h0)
    else $error("overload count kept after flag dropped");
  bo_clear_a: assert property (!f.line_loss |=> s.bo_cnt == 6'h0)
    else $error("brown-out count kept after line recovered");
  scp_stop_a: assert property (scp_hit |=>
    !gate_drive_output && s.state != fsps_pkg::ST_RUN)
    else $error("short circuit did not stop switching");
  otp_stop_a: assert property (s.otp && s.state == fsps_pkg::ST_RUN |=> !gate_drive_output)
    else $error("pulse issued during thermal shutdown");
  ss_start_a: assert property ($rose(s.state == fsps_pkg::ST_RUN) |-> soft_start_quarter)
    else $error("switching started without soft start");
  gate_run_a: assert property (gate_drive_output |-> s.state == fsps_pkg::ST_RUN)
    else $error("gate driven outside switching state");
  peak_end_a: assert property (gate_drive_output && s.blank == 8'h0 && f.cs_peak |=>
    !gate_drive_output)
    else $error("pulse not ended at peak current");
  blank_load_a: assert property ($rose(gate_drive_output) |->
    s.blank == fsps_pkg::BLANK_LOAD)
    else $error("blanking not loaded at turn-on");
  ovp_latch_a: assert property (s.state != fsps_pkg::ST_LATCH && f.vcc_ovp &&
    s.ovp_cnt == 16'(OVP_CYCLES - 1) |=> latched_fault)
    else $error("supply overvoltage did not latch");
  tlow_latch_a: assert property (s.state != fsps_pkg::ST_LATCH && f.tmr_low &&
    s.tlow_cnt == 16'(fsps_pkg::TLATCH_CYC - 1) |=> latched_fault)
    else $error("timer pull-down did not latch");
  latch_exit_a: assert property (s.state == fsps_pkg::ST_LATCH && !f.vcc_latch_hold |=>
    !latched_fault && startup_source_on)
    else $error("latch not released at release level");
  restart_level_a: assert property (s.state == fsps_pkg::ST_WAIT_RESTART &&
    f.vcc_restart_ok |=> s.state != fsps_pkg::ST_CHARGE)
    else $error("restart above fault restart level");
  burst_enter_a: assert property (s.state == fsps_pkg::ST_RUN && f.fb_burst_low |=>
    burst_active || s.state != fsps_pkg::ST_RUN)
    else $error("burst not entered at low feedback");
  xdis_src_a: assert property (s.state == fsps_pkg::ST_XDIS |-> startup_source_on)
    else $error("source off during discharge phase");
  recon_off_a: assert property (s.state == fsps_pkg::ST_RECON |-> !startup_source_on)
    else $error("source on before reconnect level");
  recon_exit_a: assert property (s.state == fsps_pkg::ST_RECON && !f.vcc_reconnect_ok &&
    !f.vcc_ovp && !f.tmr_low |=> startup_source_on)
    else $error("source not on at reconnect level");
  xdis_end_a: assert property (s.state == fsps_pkg::ST_XDIS && !f.line_at_supply && tick &&
    s.xcnt == (s.xfirst ? fsps_pkg::XC_FIRST : fsps_pkg::XC_REPEAT) - 6'h1 &&
    !f.vcc_ovp && !f.tmr_low |=> s.state == fsps_pkg::ST_XDET)
    else $error("discharge phase length wrong");
  apb_single_a: assert property (pready |=> !pready)
    else $error("ready held past one access cycle");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error flagged without ready");
endmodule // fsps_top
`default_nettype wire

// ### rtl/fsps_pkg.sv
// Behaviour
// - Supply reaching stop-charge level turns start-up source off, then line is watched.
// - Switching starts only if line appears before supply falls to start deadline.
// - No line within start window counts as brown-out; gate drive stays low.
// - Supply dropping to fault restart level turns start-up source on again.
// - Supply below undervoltage level while switching stops pulses, source back on.
// - Faults use fault restart level, not undervoltage level, as lower lockout.
// - Soft start selects quarter timer charge until timer passes its end level.
// - Feedback below burst enter level suspends switching; above exit level resumes.
// - Overload flag counts timer cycles, clears on drop; count 17 trips overload.
// - Line-loss flag counts timer cycles, clears on recovery; count 17 means brown-out.
// - Sense above short-circuit level after short blanking stops switching, auto-restarts.
// - Over-temperature stops switching with hysteresis, using reduced lower lockout.
// - Supply overvoltage held 60 us latches off until supply falls below release.
// - Timer pin held low 12 us outside ST_CHARGE latches the device off.
// - Line absent: source turns on for discharge after 32 timer cycles.
// - First discharge lasts 16 cycles, then source off 16 cycles to detect line.
// - Repeat 48 cycle discharge and 16 cycle detect until line reaches supply.
// - After reconnection source stays off until supply falls to reconnect level.
// - Two blanking intervals after turn-on; current comparator ignored during them.
// - Drive pulse ends when sensed current reaches feedback-set peak.
// - One timer cycle is a full timing-capacitor ramp; it clocks the overload, brown-out and line-absence counters.
package fsps_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OVP_TIME_NS = 60000;
  localparam int OVP_CYC = (OVP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TLATCH_TIME_NS = 12000;
  localparam int TLATCH_CYC = (TLATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_SHORT_NS = 270;
  localparam int LEB_LONG_NS = 400;
  localparam int LEB_SHORT_CYC = (LEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_LONG_CYC = (LEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BLANK_LOAD = 8'(LEB_LONG_CYC);
  localparam logic [7:0] BLANK_SHORT_LEFT = 8'(LEB_LONG_CYC - LEB_SHORT_CYC);
  localparam logic [5:0] FAULT_COUNT = 6'h11;
  localparam logic [5:0] XC_DELAY = 6'h20;
  localparam logic [5:0] XC_FIRST = 6'h10;
  localparam logic [5:0] XC_DETECT = 6'h10;
  localparam logic [5:0] XC_REPEAT = 6'h30;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_XC_EN = 1;

  typedef enum logic [3:0] {
    ST_CHARGE, ST_DETECT, ST_WAIT_RESTART, ST_RUN, ST_LATCH,
    ST_XWAIT, ST_XDIS, ST_XDET, ST_RECON
  } fsps_state_t;

  typedef struct packed {
    logic vcc_stop;
    logic vcc_deadline;
    logic vcc_uvlo_ok;
    logic vcc_restart_ok;
    logic vcc_reconnect_ok;
    logic vcc_latch_hold;
    logic vcc_ovp;
    logic line_present;
    logic line_loss;
    logic line_at_supply;
    logic fb_burst_low;
    logic fb_burst_high;
    logic fb_overload;
    logic cs_peak;
    logic cs_short;
    logic temp_hot;
    logic temp_cool;
    logic tmr_low;
    logic tmr_phase;
    logic tmr_ss_done;
    logic osc_set;
  } fsps_flags_t;

  typedef struct packed {
    fsps_flags_t sync1;
    fsps_flags_t sync2;
    logic phase_d;
    fsps_state_t state;
    logic gate;
    logic src;
    logic ss;
    logic burst;
    logic otp;
    logic latched;
    logic xfirst;
    logic [7:0] blank;
    logic [5:0] xcnt;
    logic [5:0] olp_cnt;
    logic [5:0] bo_cnt;
    logic [15:0] ovp_cnt;
    logic [15:0] tlow_cnt;
    logic [1:0] ctrl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } fsps_regs_t;
endpackage

// ### bench/fsps_stage_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_stage_model #(
  parameter int LINE_ON_V = 120
) (
  // Clock
  input wire logic sys_clk,
  // Operating point: supply in 0.1 V, line in V, feedback in mV
  input wire logic [9:0] vcc_dv,
  input wire logic [9:0] hv_v,
  input wire logic [11:0] fb_mv,
  input wire logic hot,
  input wire logic ss_done,
  input wire logic tpull,
  input wire logic sc,
  // Drive from the block
  input wire logic gate,
  // Comparator levels
  output var fsps_pkg::fsps_flags_t flags
);
  logic [7:0] tcnt = 8'h00;
  logic [7:0] on_cnt = 8'h00;
  always_ff @(posedge sys_clk) begin
    tcnt <= tcnt + 8'h01;
    on_cnt <= gate ? on_cnt + 8'h01 : 8'h00;
    flags.vcc_stop <= vcc_dv >= 10'h09b;
    flags.vcc_deadline <= vcc_dv > 10'h078;
    flags.vcc_uvlo_ok <= vcc_dv > 10'h055;
    flags.vcc_restart_ok <= vcc_dv > 10'h037;
    flags.vcc_reconnect_ok <= vcc_dv > 10'h035;
    flags.vcc_latch_hold <= vcc_dv > 10'h019;
    flags.vcc_ovp <= vcc_dv > 10'h109;
    flags.line_present <= hv_v > 10'(LINE_ON_V);
    flags.line_loss <= hv_v < 10'h061;
    flags.line_at_supply <= (14'(hv_v) * 14'h00a) <= 14'(vcc_dv);
    flags.fb_burst_low <= fb_mv < 12'h2bc;
    flags.fb_burst_high <= fb_mv > 12'h320;
    flags.fb_overload <= fb_mv > 12'he74;
    // Current passes the peak early, while blanking still runs
    flags.cs_peak <= on_cnt >= 8'h14;
    flags.cs_short <= sc;
    flags.temp_hot <= hot;
    flags.temp_cool <= !hot;
    flags.tmr_low <= tpull;
    flags.tmr_phase <= tcnt[2];
    flags.tmr_ss_done <= ss_done;
    flags.osc_set <= tcnt == 8'h00;
  end
endmodule // fsps_stage_model
`default_nettype wire

// ### bench/test_fsps_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module test_fsps_top;
  localparam int LIMIT = 20000;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic gate_drive_output, startup_source_on, soft_start_quarter, burst_active, latched_fault;
  logic [9:0] vcc_dv, hv_v;
  logic [11:0] fb_mv;
  logic hot, ss_done, tpull, sc;
  fsps_pkg::fsps_flags_t comp_flags;
  int err_count = 0, samples_checked = 0, cyc = 0, n;
  fsps_top #(.OVP_CYCLES(20)) fsps_top_i (.sys_clk, .rst, .comp_flags, .gate_drive_output,
    .startup_source_on, .soft_start_quarter, .burst_active, .latched_fault, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  fsps_stage_model fsps_stage_model_i (.sys_clk, .vcc_dv, .hv_v, .fb_mv, .hot, .ss_done,
    .tpull, .sc, .gate(gate_drive_output), .flags(comp_flags));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      $display("BAD run expected end seen hang");
      give_verdict();
    end
  end
  task automatic ticks(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic st(input logic [3:0] e);
    apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
    `CHK("state", e, rd[8:5])
  endtask
  task automatic do_rst;
    rst <= 1'b1;
    vcc_dv <= 10'h000;
    hv_v <= 10'h000;
    fb_mv <= 12'h7d0;
    hot <= 1'b0;
    ss_done <= 1'b0;
    tpull <= 1'b0;
    sc <= 1'b0;
    ticks(12);
    rst <= 1'b0;
    ticks(1);
  endtask
  task automatic to_run;
    do_rst();
    vcc_dv <= 10'h0a0;
    hv_v <= 10'h0c8;
    ss_done <= 1'b1;
    ticks(16);
  endtask
  task automatic t_regs;
    `CHK("gate", 1'b0, gate_drive_output)
    `CHK("source", 1'b1, startup_source_on)
    apb(1'b0, fsps_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h3, rd)
    `CHK("slverr", 1'b0, er)
    apb(1'b1, fsps_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, fsps_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("err data", 32'h0, rd)
    apb(1'b1, fsps_pkg::ADDR_CTRL, 32'h3);
  endtask
  task automatic t_start;
    vcc_dv <= 10'h0a0;
    ticks(8);
    `CHK("source", 1'b0, startup_source_on)
    st(4'h1);
    hv_v <= 10'h0c8;
    ticks(8);
    st(4'h3);
    `CHK("soft start", 1'b1, soft_start_quarter)
    n = 0;
    while (gate_drive_output !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (gate_drive_output === 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("pulse width", 1'b1, n >= 99 && n <= 106)
    ss_done <= 1'b1;
    ticks(8);
    `CHK("soft start", 1'b0, soft_start_quarter)
  endtask
  task automatic t_burst;
    fb_mv <= 12'h258;
    ticks(8);
    `CHK("burst", 1'b1, burst_active)
    fb_mv <= 12'h2ee;
    ticks(8);
    `CHK("burst", 1'b1, burst_active)
    fb_mv <= 12'h384;
    ticks(8);
    `CHK("burst", 1'b0, burst_active)
  endtask
  task automatic t_olp;
    fb_mv <= 12'hfa0;
    ticks(96);
    fb_mv <= 12'h7d0;
    ticks(8);
    fb_mv <= 12'hfa0;
    ticks(120);
    st(4'h3);
    ticks(32);
    st(4'h2);
    `CHK("source", 1'b0, startup_source_on)
    vcc_dv <= 10'h046;
    ticks(8);
    st(4'h2);
    vcc_dv <= 10'h032;
    ticks(8);
    st(4'h0);
    `CHK("source", 1'b1, startup_source_on)
  endtask
  task automatic t_uvlo_otp;
    to_run();
    vcc_dv <= 10'h050;
    ticks(8);
    st(4'h0);
    `CHK("source", 1'b1, startup_source_on)
    to_run();
    hot <= 1'b1;
    ticks(8);
    st(4'h2);
    vcc_dv <= 10'h046;
    ticks(8);
    st(4'h2);
  endtask
  task automatic t_latch;
    to_run();
    vcc_dv <= 10'h10e;
    ticks(10);
    vcc_dv <= 10'h0a0;
    ticks(8);
    `CHK("latched", 1'b0, latched_fault)
    vcc_dv <= 10'h10e;
    ticks(30);
    `CHK("latched", 1'b1, latched_fault)
    vcc_dv <= 10'h064;
    ticks(8);
    `CHK("latched", 1'b1, latched_fault)
    vcc_dv <= 10'h014;
    ticks(8);
    `CHK("latched", 1'b0, latched_fault)
    to_run();
    tpull <= 1'b1;
    ticks(fsps_pkg::TLATCH_CYC - 50);
    `CHK("latched", 1'b0, latched_fault)
    ticks(100);
    `CHK("latched", 1'b1, latched_fault)
  endtask
  task automatic t_xcap;
    do_rst();
    hv_v <= 10'h032;
    vcc_dv <= 10'h0a0;
    ticks(8);
    vcc_dv <= 10'h06e;
    ticks(8);
    `CHK("gate", 1'b0, gate_drive_output)
    apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
    `CHK("running", 1'b0, rd[8:5] == 4'h3)
    ticks(220);
    `CHK("source", 1'b0, startup_source_on)
    ticks(64);
    st(4'h6);
    `CHK("source", 1'b1, startup_source_on)
    ticks(40);
    st(4'h6);
    ticks(80);
    st(4'h7);
    `CHK("source", 1'b0, startup_source_on)
    ticks(128);
    st(4'h6);
    `CHK("source", 1'b1, startup_source_on)
    ticks(200);
    st(4'h6);
    ticks(160);
    st(4'h7);
    hv_v <= 10'h0c8;
    ticks(8);
    st(4'h8);
    vcc_dv <= 10'h032;
    ticks(8);
    st(4'h0);
    `CHK("source", 1'b1, startup_source_on)
  endtask
  task automatic t_xend;
    do_rst();
    hv_v <= 10'h032;
    vcc_dv <= 10'h0a0;
    ticks(8);
    vcc_dv <= 10'h06e;
    ticks(300);
    st(4'h6);
    hv_v <= 10'h00a;
    ticks(6);
    `CHK("source", 1'b0, startup_source_on)
    apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
    `CHK("discharging", 1'b0, rd[8:5] == 4'h6)
  endtask
  task automatic t_scp;
    to_run();
    sc <= 1'b1;
    n = 0;
    while (gate_drive_output !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    ticks(80);
    `CHK("gate", 1'b0, gate_drive_output)
    st(4'h2);
    sc <= 1'b0;
    vcc_dv <= 10'h032;
    ticks(8);
    vcc_dv <= 10'h0a0;
    ticks(16);
    st(4'h3);
  endtask
  task automatic t_bo;
    to_run();
    apb(1'b1, fsps_pkg::ADDR_CTRL, 32'h1);
    hv_v <= 10'h05a;
    ticks(96);
    hv_v <= 10'h0c8;
    ticks(8);
    hv_v <= 10'h05a;
    ticks(120);
    st(4'h3);
    ticks(32);
    st(4'h2);
    `CHK("gate", 1'b0, gate_drive_output)
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    do_rst();
    t_regs();
    t_start();
    t_burst();
    t_olp();
    t_uvlo_otp();
    t_latch();
    t_scp();
    t_bo();
    t_xcap();
    t_xend();
    give_verdict();
  end
endmodule // test_fsps_top
`default_nettype wire
